// *** design/burner_defines.svh ***
// Timing and count constants for the gas burner sequencer.
// Assumes a 25 MHz system clock; long phases are counted in 100 ms ticks.
`ifndef BURNER_DEFINES_SVH
`define BURNER_DEFINES_SVH

`define CLK_HZ              25000000
`define TICK_MS             100
`define TICK_CYC_DEF        ((`CLK_HZ / 1000) * `TICK_MS)

`define T_WAIT_MS           12000
`define T_PREIGN_MS         3000
`define T_STRAY_MS          5000
`define T_SAFETY_SHORT_MS   5000
`define T_POST_SHORT_MS     4000
`define T_SAFETY_LONG_MS    10000
`define T_POST_LONG_MS      9000
`define T_V2_MS             25000
`define T_HOLD_MS           3000
`define T_POWERUP_MS        2500

`define T_LOCK_LIT_MS       10000
`define T_LOCK_DARK1_MS     600
`define T_LOCK_DARK2_MS     1200
`define T_SPULSE_MS         300
`define T_LPULSE_MS         900
`define T_SPAUSE_MS         300
`define T_LPAUSE_MS         1200

`define MAX_RECYCLE         3'h4

`endif

// *** design/burner_pkg.sv ***
// Types and shared arithmetic for the gas burner sequencer.
// Relies on burner_defines.svh for the tick length.
`include "burner_defines.svh"

package burner_pkg;

    typedef logic [8:0] tick_t;

    typedef enum logic [1:0] {
        CAUSE_NONE,
        CAUSE_FLAME,
        CAUSE_STRAY,
        CAUSE_MANUAL
    } cause_e;

    typedef enum logic [3:0] {
        DISP_OFF,
        DISP_WAIT,
        DISP_PREIGN,
        DISP_SAFETY,
        DISP_POST,
        DISP_V2,
        DISP_RUN,
        DISP_LOWMAINS,
        DISP_C_FLAME,
        DISP_C_STRAY,
        DISP_C_MANUAL
    } disp_e;

    typedef enum logic [1:0] {
        SYM_SPULSE,
        SYM_LPULSE,
        SYM_SPAUSE,
        SYM_LPAUSE
    } sym_e;

    typedef struct packed {
        logic [2:0]      last;
        logic [7:0][1:0] sym;
    } pat_s;

    // Least times round up to whole ticks
    function automatic tick_t ms_to_ticks(input int unsigned ms);
        return tick_t'((ms + `TICK_MS - 1) / `TICK_MS);
    endfunction

endpackage

// *** design/gas_burner_sequencer.sv ***
// Two-stage gas burner sequencer: phase timing, flame supervision,
// lockout with non-volatile cause, button handling, low mains handling.
// Assumes all inputs synchronous to clk_sys and an external NV cell for the cause.
`timescale 1ns/1ns
`include "burner_defines.svh"

// Operation
// - Timings: wait 12, pre-ign 3, stray 5, V2 delay 25; safety/post by model.
// - Flame loss in operation restarts the sequence, at most four times.
// - Most recent lockout cause is kept in non-volatile storage.
// - Start-up begins only while mains is above the 187 V start level; a restart after flame loss enters wait without checking mains_start_ok.
// - Mains below 160 V in start-up or run: all off, wait, no lockout.
// - From low-mains wait, restart once mains is above 187 V again.
// - Each normal phase blinks its own LED pattern continuously.
// - Lockout LED: lit 10 s, dark 0.6 s, cause code, dark 1.2 s, repeat.
// - No flame by end of safety time gives lockout, cause code 1111.
// - Flame during stray-light check gives lockout with stray-light cause.
// - Stray-light check covers the last 5 s of waiting, before ignition.
// - Button press in lockout clears it and starts a fresh cycle.
// - Button held over 3 s in start-up or run, then released: manual lockout.
// - Manual lockout reports its own distinct cause code.
// - After power-up with stored lockout, re-enter lockout within 2 to 3 s.
// - Power loss never clears a lockout; only a button press does.
// - Flame lost while running restarts; no flame after safety time locks out.
module gas_burner_sequencer
    import burner_pkg::*;
#(
    parameter int unsigned TICK_CYC = `TICK_CYC_DEF
) (
    input  wire logic  clk_sys,
    input  wire logic  rst_n,
    input  wire logic  model_long,
    input  wire logic  demand,
    input  wire logic  mains_start_ok,
    input  wire logic  mains_low,
    input  wire logic  ionisation_flame_in,
    input  wire logic  int_button,
    input  wire logic  external_button,
    input  wire cause_e nv_cause_in,
    output logic        nv_wr_en,
    output cause_e      nv_wr_data,
    output logic        ignition_out,
    output logic        first_stage_valve,
    output logic        second_stage_valve,
    output logic        alarm_out,
    output logic        led_out
);

    typedef enum {
        ST_POWERUP,
        ST_IDLE,
        ST_WAIT,
        ST_STRAY,
        ST_PREIGN,
        ST_SAFETY,
        ST_POST,
        ST_V2DELAY,
        ST_RUN,
        ST_LOWMAINS,
        ST_LOCKOUT
    } state_e;

    state_e     state_ff;
    state_e     nxt_state;
    cause_e     cause_ff;
    cause_e     nxt_cause;
    logic [21:0] tick_cnt_ff;
    logic       tick_ff;
    tick_t      tmr_ff;
    logic [2:0] recycle_ff;
    logic       btn_prev_ff;
    logic       btn_armed_ff;
    tick_t      hold_ff;
    logic       nv_loaded_ff;
    logic       nv_wr_en_ff;
    cause_e     nv_wr_data_ff;
    logic       ign_ff;
    logic       v1_ff;
    logic       v2_ff;
    logic       alarm_ff;
    logic       btn;
    logic       btn_press;
    logic       btn_release;
    logic       manual_req;
    logic       flame_loss;
    tick_t      safety_len;
    tick_t      post_len;

    led_if lif();

    function automatic logic is_active(input state_e s);
        return (s == ST_WAIT) || (s == ST_STRAY) || (s == ST_PREIGN) ||
               (s == ST_SAFETY) || (s == ST_POST) || (s == ST_V2DELAY) ||
               (s == ST_RUN);
    endfunction

    function automatic logic tmr_done(input tick_t t, input tick_t len, input logic tk);
        return tk && (t + tick_t'(1) >= len);
    endfunction

    assign safety_len = model_long ? ms_to_ticks(`T_SAFETY_LONG_MS)
                                   : ms_to_ticks(`T_SAFETY_SHORT_MS);
    assign post_len   = model_long ? ms_to_ticks(`T_POST_LONG_MS)
                                   : ms_to_ticks(`T_POST_SHORT_MS);

    assign btn         = int_button | external_button;
    assign btn_press   = btn & ~btn_prev_ff;
    assign btn_release = ~btn & btn_prev_ff;
    assign manual_req  = btn_release && btn_armed_ff &&
                         (hold_ff >= ms_to_ticks(`T_HOLD_MS));
    assign flame_loss  = !ionisation_flame_in;

    // Base tick; every phase timer counts these, so a sim shortens TICK_CYC only
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_ff <= 22'h0;
            tick_ff     <= 1'b0;
        end else if (tick_cnt_ff >= 22'(TICK_CYC - 1)) begin
            tick_cnt_ff <= 22'h0;
            tick_ff     <= 1'b1;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 22'h1;
            tick_ff     <= 1'b0;
        end
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_cause = cause_ff;
        case (state_ff)
            ST_POWERUP: begin
                // stored lockout comes back after the power-up delay
                if (nv_loaded_ff &&
                    tmr_done(tmr_ff, ms_to_ticks(`T_POWERUP_MS), tick_ff)) begin
                    nxt_state = (cause_ff != CAUSE_NONE) ? ST_LOCKOUT : ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (demand && mains_start_ok) begin
                    nxt_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (tmr_done(tmr_ff, ms_to_ticks(`T_WAIT_MS - `T_STRAY_MS), tick_ff)) begin
                    nxt_state = ST_STRAY;
                end
            end
            ST_STRAY: begin
                if (ionisation_flame_in) begin
                    nxt_state = ST_LOCKOUT;
                    nxt_cause = CAUSE_STRAY;
                end else if (tmr_done(tmr_ff, ms_to_ticks(`T_STRAY_MS), tick_ff)) begin
                    nxt_state = ST_PREIGN;
                end
            end
            ST_PREIGN: begin
                if (tmr_done(tmr_ff, ms_to_ticks(`T_PREIGN_MS), tick_ff)) begin
                    nxt_state = ST_SAFETY;
                end
            end
            ST_SAFETY: begin
                // no flame at end of safety time
                if (tmr_done(tmr_ff, safety_len, tick_ff)) begin
                    if (flame_loss) begin
                        nxt_state = ST_LOCKOUT;
                        nxt_cause = CAUSE_FLAME;
                    end else begin
                        nxt_state = ST_POST;
                    end
                end
            end
            ST_POST, ST_V2DELAY, ST_RUN: begin
                if (flame_loss) begin
                    if (recycle_ff >= `MAX_RECYCLE) begin
                        nxt_state = ST_LOCKOUT;
                        nxt_cause = CAUSE_FLAME;
                    end else begin
                        nxt_state = ST_WAIT;
                    end
                end else if (state_ff == ST_POST &&
                             tmr_done(tmr_ff, post_len, tick_ff)) begin
                    nxt_state = ST_V2DELAY;
                end else if (state_ff == ST_V2DELAY &&
                             tmr_done(tmr_ff, ms_to_ticks(`T_V2_MS), tick_ff)) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_LOWMAINS: begin
                if (!demand) begin
                    nxt_state = ST_IDLE;
                end else if (mains_start_ok && !mains_low) begin
                    nxt_state = ST_WAIT;
                end
            end
            ST_LOCKOUT: begin
                // only a press with power applied clears it
                if (btn_press) begin
                    nxt_state = ST_IDLE;
                    nxt_cause = CAUSE_NONE;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase

        // Overrides shared by every start-up and run phase, strongest last
        if (is_active(state_ff)) begin
            if (!demand) begin
                nxt_state = ST_IDLE;
                nxt_cause = cause_ff;
            end
            // low mains is a shutdown, not a lockout
            if (mains_low) begin
                nxt_state = ST_LOWMAINS;
                nxt_cause = cause_ff;
            end
            if (manual_req) begin
                nxt_state = ST_LOCKOUT;
                nxt_cause = CAUSE_MANUAL;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_POWERUP;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // cause is loaded from the NV cell after reset release
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cause_ff     <= CAUSE_NONE;
            nv_loaded_ff <= 1'b0;
        end else if (!nv_loaded_ff) begin
            cause_ff     <= nv_cause_in;
            nv_loaded_ff <= 1'b1;
        end else begin
            cause_ff <= nxt_cause;
        end
    end

    // every change of the stored cause is written through
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            nv_wr_en_ff   <= 1'b0;
            nv_wr_data_ff <= CAUSE_NONE;
        end else begin
            nv_wr_en_ff <= nv_loaded_ff && (nxt_cause != cause_ff);
            if (nv_loaded_ff && (nxt_cause != cause_ff)) begin
                nv_wr_data_ff <= nxt_cause;
            end
        end
    end

    // phase timer restarts on every state change
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tmr_ff <= '0;
        end else if (nxt_state != state_ff) begin
            tmr_ff <= '0;
        end else if (tick_ff && tmr_ff != '1) begin
            tmr_ff <= tmr_ff + tick_t'(1);
        end
    end

    // repetition count, cleared by idle or lockout
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            recycle_ff <= 3'h0;
        end else if (state_ff == ST_IDLE || state_ff == ST_LOCKOUT) begin
            recycle_ff <= 3'h0;
        end else if (nxt_state == ST_WAIT &&
                     (state_ff == ST_POST || state_ff == ST_V2DELAY ||
                      state_ff == ST_RUN)) begin
            recycle_ff <= recycle_ff + 3'h1;
        end
    end

    // Only a press that began in an active phase arms the hold check, so the
    // press that clears a lockout cannot turn into a manual lockout.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            btn_prev_ff  <= 1'b0;
            btn_armed_ff <= 1'b0;
            hold_ff      <= '0;
        end else begin
            btn_prev_ff <= btn;
            if (!is_active(state_ff) || !btn) begin
                btn_armed_ff <= 1'b0;
                hold_ff      <= '0;
            end else if (btn_press) begin
                btn_armed_ff <= 1'b1;
                hold_ff      <= '0;
            end else if (tick_ff && hold_ff != '1) begin
                hold_ff <= hold_ff + tick_t'(1);
            end
        end
    end

    // load outputs, registered from the next state
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ign_ff   <= 1'b0;
            v1_ff    <= 1'b0;
            v2_ff    <= 1'b0;
            alarm_ff <= 1'b0;
        end else begin
            ign_ff   <= (nxt_state == ST_PREIGN) || (nxt_state == ST_SAFETY) ||
                        (nxt_state == ST_POST);
            v1_ff    <= (nxt_state == ST_SAFETY) || (nxt_state == ST_POST) ||
                        (nxt_state == ST_V2DELAY) || (nxt_state == ST_RUN);
            v2_ff    <= (nxt_state == ST_RUN);
            alarm_ff <= (nxt_state == ST_LOCKOUT);
        end
    end

    always_comb begin
        lif.tick      = tick_ff;
        lif.lock_mode = (state_ff == ST_LOCKOUT);
        case (state_ff)
            ST_WAIT, ST_STRAY: lif.disp = DISP_WAIT;
            ST_PREIGN:         lif.disp = DISP_PREIGN;
            ST_SAFETY:         lif.disp = DISP_SAFETY;
            ST_POST:           lif.disp = DISP_POST;
            ST_V2DELAY:        lif.disp = DISP_V2;
            ST_RUN:            lif.disp = DISP_RUN;
            ST_LOWMAINS:       lif.disp = DISP_LOWMAINS;
            ST_LOCKOUT: begin
                case (cause_ff)
                    CAUSE_STRAY:  lif.disp = DISP_C_STRAY;
                    CAUSE_MANUAL: lif.disp = DISP_C_MANUAL;
                    default:      lif.disp = DISP_C_FLAME;
                endcase
            end
            default:           lif.disp = DISP_OFF;
        endcase
    end

    led_flasher u_flasher (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .lif     (lif)
    );

    assign nv_wr_en           = nv_wr_en_ff;
    assign nv_wr_data         = nv_wr_data_ff;
    assign ignition_out       = ign_ff;
    assign first_stage_valve  = v1_ff;
    assign second_stage_valve = v2_ff;
    assign alarm_out          = alarm_ff;
    assign led_out            = lif.led;

endmodule

// *** design/led_flasher.sv ***
// LED flash-code generator: phase patterns in normal mode, and the
// lit / dark / code / dark cycle in lockout. Advances on the 100 ms tick.
`timescale 1ns/1ns
`include "burner_defines.svh"

module led_flasher
    import burner_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic rst_n,
    led_if.flash      lif
);

    typedef enum {FPH_LIT, FPH_DARK1, FPH_CODE, FPH_DARK2} fph_e;

    fph_e       fph_ff;
    logic [2:0] idx_ff;
    tick_t      cnt_ff;
    disp_e      last_disp_ff;
    logic       last_lock_ff;
    logic       led_ff;
    pat_s       pat;
    tick_t      dur;

    function automatic pat_s pattern(input disp_e d);
        pat_s p;
        p = '{last: 3'h0, sym: {8{SYM_LPAUSE}}};
        case (d)
            DISP_WAIT:     p = '{3'h5, {SYM_LPAUSE, SYM_LPAUSE, SYM_LPAUSE, SYM_SPULSE,
                                 SYM_SPAUSE, SYM_SPULSE, SYM_SPAUSE, SYM_SPULSE}};
            DISP_PREIGN:   p = '{3'h7, {SYM_LPAUSE, SYM_SPULSE, SYM_SPAUSE, SYM_SPULSE,
                                 SYM_SPAUSE, SYM_SPULSE, SYM_SPAUSE, SYM_SPULSE}};
            DISP_SAFETY:   p = '{3'h3, {SYM_LPAUSE, SYM_LPAUSE, SYM_LPAUSE, SYM_LPAUSE,
                                 SYM_LPAUSE, SYM_SPULSE, SYM_SPAUSE, SYM_LPULSE}};
            DISP_POST:     p = '{3'h3, {SYM_LPAUSE, SYM_LPAUSE, SYM_LPAUSE, SYM_LPAUSE,
                                 SYM_LPAUSE, SYM_LPULSE, SYM_SPAUSE, SYM_LPULSE}};
            DISP_V2:       p = '{3'h5, {SYM_LPAUSE, SYM_LPAUSE, SYM_LPAUSE, SYM_SPULSE,
                                 SYM_SPAUSE, SYM_SPULSE, SYM_SPAUSE, SYM_LPULSE}};
            DISP_RUN:      p = '{3'h1, {{6{SYM_LPAUSE}}, SYM_LPAUSE, SYM_SPULSE}};
            DISP_LOWMAINS: p = '{3'h5, {SYM_LPAUSE, SYM_LPAUSE, SYM_LPAUSE, SYM_LPULSE,
                                 SYM_SPAUSE, SYM_LPULSE, SYM_SPAUSE, SYM_LPULSE}};
            DISP_C_FLAME:  p = '{3'h6, {SYM_LPAUSE, SYM_SPULSE, SYM_SPAUSE, SYM_SPULSE,
                                 SYM_SPAUSE, SYM_SPULSE, SYM_SPAUSE, SYM_SPULSE}};
            DISP_C_STRAY:  p = '{3'h4, {SYM_LPAUSE, SYM_LPAUSE, SYM_LPAUSE, SYM_LPULSE,
                                 SYM_SPAUSE, SYM_SPULSE, SYM_SPAUSE, SYM_LPULSE}};
            DISP_C_MANUAL: p = '{3'h6, {SYM_LPAUSE, SYM_LPULSE, SYM_SPAUSE, SYM_LPULSE,
                                 SYM_SPAUSE, SYM_LPULSE, SYM_SPAUSE, SYM_LPULSE}};
            default:       p = '{last: 3'h0, sym: {8{SYM_LPAUSE}}};
        endcase
        return p;
    endfunction

    function automatic tick_t sym_ticks(input sym_e s);
        case (s)
            SYM_SPULSE: return ms_to_ticks(`T_SPULSE_MS);
            SYM_LPULSE: return ms_to_ticks(`T_LPULSE_MS);
            SYM_SPAUSE: return ms_to_ticks(`T_SPAUSE_MS);
            default:    return ms_to_ticks(`T_LPAUSE_MS);
        endcase
    endfunction

    assign pat = pattern(lif.disp);

    always_comb begin
        case (fph_ff)
            FPH_LIT:   dur = ms_to_ticks(`T_LOCK_LIT_MS);
            FPH_DARK1: dur = ms_to_ticks(`T_LOCK_DARK1_MS);
            FPH_DARK2: dur = ms_to_ticks(`T_LOCK_DARK2_MS);
            default:   dur = sym_ticks(sym_e'(pat.sym[idx_ff]));
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fph_ff       <= FPH_CODE;
            idx_ff       <= 3'h0;
            cnt_ff       <= '0;
            last_disp_ff <= DISP_OFF;
            last_lock_ff <= 1'b0;
        end else if (lif.disp != last_disp_ff || lif.lock_mode != last_lock_ff) begin
            fph_ff       <= lif.lock_mode ? FPH_LIT : FPH_CODE;
            idx_ff       <= 3'h0;
            cnt_ff       <= '0;
            last_disp_ff <= lif.disp;
            last_lock_ff <= lif.lock_mode;
        end else if (lif.tick) begin
            if (cnt_ff + tick_t'(1) >= dur) begin
                cnt_ff <= '0;
                case (fph_ff)
                    FPH_LIT:   fph_ff <= FPH_DARK1;
                    FPH_DARK1: fph_ff <= FPH_CODE;
                    FPH_DARK2: fph_ff <= FPH_LIT;
                    default: begin
                        if (idx_ff == pat.last) begin
                            idx_ff <= 3'h0;
                            fph_ff <= last_lock_ff ? FPH_DARK2 : FPH_CODE;
                        end else begin
                            idx_ff <= idx_ff + 3'h1;
                        end
                    end
                endcase
            end else begin
                cnt_ff <= cnt_ff + tick_t'(1);
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            led_ff <= 1'b0;
        end else if (last_disp_ff == DISP_OFF) begin
            led_ff <= 1'b0;
        end else begin
            led_ff <= (fph_ff == FPH_LIT) ||
                      (fph_ff == FPH_CODE &&
                       (pat.sym[idx_ff] == SYM_SPULSE || pat.sym[idx_ff] == SYM_LPULSE));
        end
    end

    assign lif.led = led_ff;

endmodule

// *** design/led_if.sv ***
// Link between the sequencer core and the LED flash-code generator.
// One clock domain; the core owns tick and display selection.
`timescale 1ns/1ns

interface led_if;
    import burner_pkg::*;

    logic  tick;
    disp_e disp;
    logic  lock_mode;
    logic  led;

    modport seq   (output tick, output disp, output lock_mode, input led);
    modport flash (input tick, input disp, input lock_mode, output led);
endinterface

// *** dv/burner_checker.sv ***
// Port-level checks for the burner sequencer.
// Sees only the top module's ports; one clock domain.
`timescale 1ns/1ns
module burner_checker
    import burner_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic demand,
    input wire logic mains_low,
    input wire logic int_button,
    input wire logic external_button,
    input wire logic ignition_out,
    input wire logic first_stage_valve,
    input wire logic second_stage_valve,
    input wire logic alarm_out,
    input wire logic led_out
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    wire btn = int_button | external_button;
    property p_lock_off;
        alarm_out |-> !(ignition_out | first_stage_valve | second_stage_valve);
    endproperty
    a_lock_off: assert property (p_lock_off) else $error("Load on in lockout");
    property p_v2;
        second_stage_valve |-> first_stage_valve && !ignition_out;
    endproperty
    a_v2: assert property (p_v2) else $error("Bad stage valve mix");
    // Pre-ignition lasts 120 cycles with a tick of 4
    property p_preign;
        $rose(first_stage_valve) |-> $past(ignition_out, 110) && !$past(ignition_out, 125);
    endproperty
    a_preign: assert property (p_preign) else $error("Pre-ignition length");
    property p_demand;
        !demand |=> !(ignition_out | first_stage_valve | second_stage_valve);
    endproperty
    a_demand: assert property (p_demand) else $error("Load on without demand");
    property p_low;
        mains_low && !alarm_out && !$fell(btn) |=> !first_stage_valve && !alarm_out;
    endproperty
    a_low: assert property (p_low) else $error("Low mains not handled");
    property p_hold;
        alarm_out && !$rose(btn) |=> alarm_out;
    endproperty
    a_hold: assert property (p_hold) else $error("Lockout left alone");
    property p_clear;
        alarm_out && $rose(btn) |=> !alarm_out;
    endproperty
    a_clear: assert property (p_clear) else $error("Lockout not cleared");
    property p_led;
        $rose(alarm_out) |-> ##[1:2] led_out ##1 led_out [*8];
    endproperty
    a_led: assert property (p_led) else $error("Lockout LED not lit");
    c_run: cover property ($rose(second_stage_valve));
    c_lock: cover property ($rose(alarm_out));
    c_clear: cover property ($fell(alarm_out));
endmodule
bind gas_burner_sequencer burner_checker chk_u (.*);

// *** dv/flame_plant.sv ***
// Flame sensor and burner model on the sequencer's far side.
// Flame follows the first-stage valve when fuel flows; stray light forces it.
`timescale 1ns/1ns
module flame_plant (
    input  wire logic clk_sys,
    input  wire logic first_stage_valve,
    input  wire logic fuel_ok,
    input  wire logic stray,
    output logic      ionisation_flame_in
);
    // One cycle lag, as a real flame never appears with the valve
    always_ff @(posedge clk_sys) begin
        ionisation_flame_in <= stray | (first_stage_valve & fuel_ok);
    end
endmodule

// *** dv/gas_burner_sequencer_test.sv ***
// Self-checking bench for the burner sequencer with a flame model.
// Tick shortened to 4 clocks; all phase figures scale from it.
`timescale 1ns/1ns
module gas_burner_sequencer_test
    import burner_pkg::*;
;
    localparam int IGN = 0, V1 = 1, V2 = 2, ALM = 3;
    logic   clk_sys = 1'b0;
    logic   rst_n = 1'b0;
    logic   model_long = 1'b0;
    logic   demand = 1'b0;
    logic   mains_start_ok = 1'b0;
    logic   mains_low = 1'b0;
    logic   int_button = 1'b0;
    logic   external_button = 1'b0;
    logic   fuel_ok = 1'b1;
    logic   stray = 1'b0;
    cause_e nv_cause_in = CAUSE_NONE;
    cause_e nv_wr_data;
    logic   nv_wr_en, ionisation_flame_in, ignition_out, first_stage_valve;
    logic   second_stage_valve, alarm_out, led_out;
    int     num_errors = 0;
    int     compares = 0;
    wire [3:0] obs = {alarm_out, second_stage_valve, first_stage_valve, ignition_out};
    gas_burner_sequencer #(.TICK_CYC(4)) dut_u (.*);
    flame_plant plant_u (.*);
    always #20 clk_sys = ~clk_sys;
    function bit ok(int n, int t);
        return n >= 4 * t - 8 && n <= 4 * t + 3;
    endfunction
    task check(logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask
    task wt(int b, logic v, int lim, output int n);
        n = 0;
        while (obs[b] !== v && n <= lim) begin
            @(posedge clk_sys);
            n++;
        end
    endtask
    task push(logic ext, int len);
        external_button <= ext;
        int_button <= !ext;
        repeat (len) @(posedge clk_sys);
        external_button <= 1'b0;
        int_button <= 1'b0;
    endtask
    task rst(cause_e c);
        nv_cause_in <= c;
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
    endtask
    task end_of_test;
        $display("Errors %0d, compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        int n;
        int s;
        void'($urandom(32'h5A03EC6A));
        rst(CAUSE_NONE);
        demand <= 1'b1;
        model_long <= 1'($urandom);
        wt(IGN, 1'b1, 700, n);
        check(n, 701); // no start
        mains_start_ok <= 1'b1;
        wt(IGN, 1'b1, 700, n);
        s = model_long ? 100 : 50;
        wt(V1, 1'b1, 200, n);
        check(ok(n, 30), 1); // preign
        wt(IGN, 1'b0, 900, n);
        check(ok(n, 2 * s - 10), 1); // ign off
        wt(V2, 1'b1, 1100, n);
        check(ok(n, 250), 1); // delay
        for (int i = 0; i < 5; i++) begin
            repeat ($urandom_range(40, 1)) @(posedge clk_sys);
            fuel_ok <= 1'b0;
            wt(V1, 1'b0, 5, n);
            fuel_ok <= 1'b1;
            wt(i < 4 ? V2 : ALM, 1'b1, 2500, n);
            check(obs, i == 4 ? 4'h8 : 4'h6); // restarts
        end
        check(nv_wr_data, CAUSE_FLAME); // cause
        push(1'b1, 1);
        stray <= 1'b1;
        wt(ALM, 1'b0, 4, n);
        check(nv_wr_data, CAUSE_NONE); // cleared
        wt(ALM, 1'b1, 600, n);
        check(ok(n, 70), 1); // stray window
        check(nv_wr_data, CAUSE_STRAY); // cause
        check(nv_wr_en, 1'b1); // write pulse
        stray <= 1'b0;
        push(1'b0, 1);
        fuel_ok <= 1'b0;
        wt(V1, 1'b1, 700, n);
        wt(ALM, 1'b1, 500, n);
        check(ok(n, s), 1); // safety end
        fuel_ok <= 1'b1;
        push(1'b0, 1);
        wt(V2, 1'b1, 2600, n);
        push(1'b0, 20);
        wt(ALM, 1'b1, 10, n);
        check(n, 11); // short press
        push(1'b0, 130);
        wt(ALM, 1'b1, 5, n);
        check(nv_wr_data, CAUSE_MANUAL); // cause
        push(1'b1, 1);
        wt(V1, 1'b1, 700, n);
        mains_low <= 1'b1;
        mains_start_ok <= 1'b0;
        wt(V1, 1'b0, 3, n);
        check(obs, 0); // shutdown
        repeat (20) @(posedge clk_sys);
        mains_low <= 1'b0;
        mains_start_ok <= 1'b1;
        wt(IGN, 1'b1, 700, n);
        check(ok(n, 120), 1); // restart
        demand <= 1'b0;
        wt(IGN, 1'b0, 3, n);
        check(obs, 0); // idle
        rst(CAUSE_STRAY);
        wt(ALM, 1'b1, 200, n);
        check(ok(n, 25), 1); // stored lockout
        end_of_test;
    end
    // Full run is near 15000 cycles, or 17500 with the long model; well past that means a hang
    initial begin
        repeat (60000) @(posedge clk_sys);
        num_errors++;
        end_of_test;
    end
endmodule
